// File: hdl/trig_route_pkg.sv
package trig_route_pkg;

    // register byte offsets
    localparam logic [7:0] CONV_CTRL_OFF = 8'h00; // converter trigger control
    localparam logic [7:0] SERIAL_CTRL_OFF = 8'h04; // serial port source selects
    localparam logic [7:0] CMP_CTRL_OFF = 8'h08; // comparator trigger mode
    localparam logic [7:0] DMA_CTRL_OFF = 8'h0C; // dma trigger enables
    localparam logic [7:0] TIMER_TRIG_OFF = 8'h10; // timer trigger selects
    localparam logic [7:0] FLEX_TRIG_OFF = 8'h14; // flexible i/o trigger selects
    localparam logic [7:0] STATUS_OFF = 8'h18; // read-only live state
    localparam int NUM_CFG = 6; // writable registers
    localparam int NUM_REGS = 7; // all mapped registers

    // field positions
    localparam int CONV_ALT_BIT = 0; // conv_alt_trigger_enable
    localparam int CONV_SEL_LSB = 1; // conv_trigger_source_select [4:1]
    localparam int CONV_PRE_BIT = 5; // conv_pretrigger_ab_select
    localparam int SER0_TX_LSB = 0; // serial0_tx_source_select [1:0]
    localparam int SER1_TX_LSB = 2; // serial1_tx_source_select [3:2]
    localparam int SER0_RX_BIT = 4; // serial0_rx_source_select
    localparam int SER1_RX_BIT = 5; // serial1_rx_source_select
    localparam int CMP_COMPARATOR_TRIGGER_MODE_BIT = 0; // comparator_trigger_mode
    localparam int DMA_EN0_BIT = 0; // dma channel 0 trigger enable
    localparam int DMA_EN1_BIT = 1; // dma channel 1 trigger enable
    localparam int TIMER_GTB_LSB = 12; // global_timebase_enable per timer
    localparam int SEL_W = 4; // width of each trigger_input_select

    // reset value, masks
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] WR_MASK [NUM_CFG] = '{
        32'h0000_003F, 32'h0000_003F, 32'h0000_0001,
        32'h0000_0003, 32'h0000_7FFF, 32'h0000_FFFF
    };

    // trigger source codes
    localparam logic [3:0] SRC_EXT_PIN = 4'h0; // external_trigger_pin
    localparam logic [3:0] SRC_CMP_OUT = 4'h1; // comparator_output
    localparam logic [3:0] SRC_PIT_F0 = 4'h2; // periodic_flag_zero
    localparam logic [3:0] SRC_PIT_F1 = 4'h3; // periodic_flag_one
    localparam logic [3:0] SRC_TOF0 = 4'h4; // timer0 counter_overflow_flag
    localparam logic [3:0] SRC_TOF1 = 4'h5; // timer1 counter_overflow_flag
    localparam logic [3:0] SRC_TOF2 = 4'h6; // timer2 counter_overflow_flag
    localparam logic [3:0] SRC_RTC_ALARM = 4'h7; // clock alarm
    localparam logic [3:0] SRC_RTC_SEC = 4'h8; // clock seconds
    localparam logic [3:0] SRC_LOW_POWER_TIMER = 4'h9; // low_power_timer trigger
    localparam int NUM_SRC = 16; // 10-15 read low

    // serial transmit modulation choices
    localparam logic [1:0] TX_PLAIN = 2'h0; // no modulation
    localparam logic [1:0] TX_MOD_T1 = 2'h1; // timer1 channel 0
    localparam logic [1:0] TX_MOD_T2 = 2'h2; // timer2 channel 0

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // event sources
    typedef struct packed {
        logic external_trigger_pin; // trigger pin level
        logic comparator_output; // comparator result
        logic periodic_flag_zero; // periodic timer flag 0
        logic periodic_flag_one; // periodic timer flag 1
        logic [2:0] counter_overflow_flag; // per timer overflow
        logic rtc_alarm; // clock alarm flag
        logic rtc_seconds; // clock seconds flag
        logic low_power_timer_trigger; // low power timer trigger
        logic t1_chan0_event_flag; // timer1 channel 0 flag
        logic t1_chan1_event_flag; // timer1 channel 1 flag
        logic t2_chan0_event_flag; // timer2 channel 0 flag
    } trig_src_t;

    // converter trigger pair
    typedef struct packed {
        logic trigger; // hardware trigger
        logic pretrigger_b; // 0 = a conversion, 1 = b
    } conv_trig_t;

endpackage : trig_route_pkg

// File: hdl/trigger_select.sv
`timescale 1ns/10ps
`default_nettype none
module trigger_select
    import trig_route_pkg::*;
#(
    parameter int N = NUM_SRC // number of source lines
) (
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // synchronous reset, low
    input wire logic [N-1:0] src_i, // source lines
    input wire logic [$clog2(N)-1:0] sel_i, // source code
    output logic trig_o // registered chosen source
);

    logic nxt_trig; // next output
    logic trig_ff; // output register

    // pick the coded source
    always_comb begin
        nxt_trig = src_i[sel_i];
    end

    // register the choice
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            trig_ff <= 1'b0;
        end else begin
            trig_ff <= nxt_trig;
        end
    end

    assign trig_o = trig_ff;

endmodule : trigger_select
`default_nettype wire

// File: hdl/peripheral_trigger_routing.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - alt disabled: timer1 ch0 to a, ch1 to b; both in one cycle go to b
// - converter trigger from selected source, a/b chosen
// - low power timer triggers comparator when enabled
// - serial transmit modulated by timer1 or timer2 ch0
// - periodic flags trigger dma channels 0 and 1
// - serial receive may come from comparator output
module peripheral_trigger_routing
    import trig_route_pkg::*;
#(
    parameter int NUM_TIMERS = 3, // timer units
    parameter int NUM_FLEX = 4, // flexible i/o timers
    parameter int TB_W = 16 // timebase counter width
) (
    input wire logic clk_i, // system bus clock
    input wire logic rst_n_i, // synchronous reset, low
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    // sources
    input wire trig_src_t src_i, // event sources
    input wire logic [TB_W-1:0] t1_timebase_i, // timer1 counter
    input wire logic [1:0] serial_tx_i, // serial transmit data
    input wire logic [1:0] serial_rx_pin_i, // serial receive pins
    // sinks
    output conv_trig_t conv_trig_o, // converter trigger
    output logic cmp_trigger_o, // comparator trigger
    output logic [NUM_TIMERS-1:0] timer_trigger_o, // timer trigger inputs
    output logic [NUM_TIMERS-1:0] timebase_enable_o, // use global timebase
    output logic [TB_W-1:0] timebase_count_o, // shared timebase value
    output logic [NUM_FLEX-1:0] flex_trigger_o, // flexible i/o triggers
    output logic [1:0] serial_tx_o, // serial transmit pins
    output logic [1:0] serial_rx_o, // serial receive inputs
    output logic [1:0] dma_request_o // dma channel requests
);

    // register file
    logic [31:0] cfg_ff [NUM_CFG]; // configuration words
    logic [31:0] nxt_cfg [NUM_CFG]; // next configuration
    // write channel state
    logic aw_have_ff, nxt_aw_have; // address held
    logic [7:0] aw_addr_ff, nxt_aw_addr; // held address
    logic w_have_ff, nxt_w_have; // data held
    logic [31:0] w_data_ff, nxt_w_data; // held data
    logic [3:0] w_strb_ff, nxt_w_strb; // held byte enables
    logic bvalid_ff, nxt_bvalid; // response pending
    logic [1:0] bresp_ff, nxt_bresp; // response code
    // read channel state
    logic rvalid_ff, nxt_rvalid; // read data pending
    logic [31:0] rdata_ff, nxt_rdata; // read data
    logic [1:0] rresp_ff, nxt_rresp; // read response
    // routed outputs
    conv_trig_t conv_ff, nxt_conv; // converter trigger
    logic cmp_ff, nxt_cmp; // comparator trigger
    logic [1:0] tx_ff, nxt_tx; // serial transmit
    logic [1:0] rx_ff, nxt_rx; // serial receive
    logic [1:0] dma_ff, nxt_dma; // dma requests
    logic [TB_W-1:0] tb_ff, nxt_tb; // timebase copy
    // helpers
    logic [NUM_SRC-1:0] src_vec; // coded source lines
    logic conv_sel_trig; // selected converter source
    logic [31:0] status_word; // live state for reads

    // spread the source struct onto the coded lines
    always_comb begin
        src_vec = '0;
        src_vec[SRC_EXT_PIN] = src_i.external_trigger_pin;
        src_vec[SRC_CMP_OUT] = src_i.comparator_output;
        src_vec[SRC_PIT_F0] = src_i.periodic_flag_zero;
        src_vec[SRC_PIT_F1] = src_i.periodic_flag_one;
        src_vec[SRC_TOF0] = src_i.counter_overflow_flag[0];
        src_vec[SRC_TOF1] = src_i.counter_overflow_flag[1];
        src_vec[SRC_TOF2] = src_i.counter_overflow_flag[2];
        src_vec[SRC_RTC_ALARM] = src_i.rtc_alarm;
        src_vec[SRC_RTC_SEC] = src_i.rtc_seconds;
        src_vec[SRC_LOW_POWER_TIMER] = src_i.low_power_timer_trigger;
    end

    // converter source chooser, one cycle latency
    trigger_select #(.N(NUM_SRC)) u_conv_sel (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .src_i(src_vec),
        .sel_i(cfg_ff[0][CONV_SEL_LSB +: SEL_W]),
        .trig_o(conv_sel_trig)
    );

    // per-timer trigger choosers
    generate
        for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
            trigger_select #(.N(NUM_SRC)) u_sel (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .src_i(src_vec),
                .sel_i(cfg_ff[4][t*SEL_W +: SEL_W]),
                .trig_o(timer_trigger_o[t])
            );
            assign timebase_enable_o[t] = cfg_ff[4][TIMER_GTB_LSB + t];
        end
        for (genvar f = 0; f < NUM_FLEX; f++) begin : g_flex
            trigger_select #(.N(NUM_SRC)) u_sel (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .src_i(src_vec),
                .sel_i(cfg_ff[5][f*SEL_W +: SEL_W]),
                .trig_o(flex_trigger_o[f])
            );
        end
    endgenerate

    // routing of fixed paths
    always_comb begin
        // alt disabled: timer1 channel flags drive a and b directly
        if (!cfg_ff[0][CONV_ALT_BIT]) begin
            nxt_conv.trigger = src_i.t1_chan0_event_flag | src_i.t1_chan1_event_flag;
            nxt_conv.pretrigger_b = src_i.t1_chan1_event_flag;
        end else begin
            // selected source, a/b from the pretrigger select
            nxt_conv.trigger = conv_sel_trig;
            nxt_conv.pretrigger_b = cfg_ff[0][CONV_PRE_BIT];
        end
        nxt_cmp = src_i.low_power_timer_trigger & cfg_ff[2][CMP_COMPARATOR_TRIGGER_MODE_BIT];
        for (int p = 0; p < 2; p++) begin
            // transmit optionally gated by a timer channel 0 carrier
            unique case (cfg_ff[1][p*2 +: 2])
                TX_MOD_T1: nxt_tx[p] = serial_tx_i[p] & src_i.t1_chan0_event_flag;
                TX_MOD_T2: nxt_tx[p] = serial_tx_i[p] & src_i.t2_chan0_event_flag;
                default: nxt_tx[p] = serial_tx_i[p];
            endcase
        end
        nxt_rx[0] = cfg_ff[1][SER0_RX_BIT] ? src_i.comparator_output : serial_rx_pin_i[0];
        nxt_rx[1] = cfg_ff[1][SER1_RX_BIT] ? src_i.comparator_output : serial_rx_pin_i[1];
        nxt_dma[0] = src_i.periodic_flag_zero & cfg_ff[3][DMA_EN0_BIT];
        nxt_dma[1] = src_i.periodic_flag_one & cfg_ff[3][DMA_EN1_BIT];
        nxt_tb = t1_timebase_i;
    end

    // register routed outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            conv_ff <= '0;
            cmp_ff <= 1'b0;
            tx_ff <= 2'h3;
            rx_ff <= 2'h3;
            dma_ff <= '0;
            tb_ff <= '0;
        end else begin
            conv_ff <= nxt_conv;
            cmp_ff <= nxt_cmp;
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            dma_ff <= nxt_dma;
            tb_ff <= nxt_tb;
        end
    end

    // live state visible to software
    always_comb begin
        status_word = '0;
        status_word[NUM_SRC-1:0] = src_vec;
        status_word[16] = conv_ff.trigger;
        status_word[17] = conv_ff.pretrigger_b;
        status_word[18] = src_i.t1_chan0_event_flag;
        status_word[19] = src_i.t1_chan1_event_flag;
        status_word[20] = src_i.t2_chan0_event_flag;
    end

    // axi write path: address and data in any order, then one response
    always_comb begin
        logic aw_take; // address accepted now
        logic w_take; // data accepted now
        logic [7:0] addr; // effective address
        logic [2:0] idx; // word index
        aw_take = s_axi_awvalid & s_axi_awready;
        w_take = s_axi_wvalid & s_axi_wready;
        nxt_aw_have = aw_have_ff | aw_take;
        nxt_aw_addr = aw_take ? s_axi_awaddr : aw_addr_ff;
        nxt_w_have = w_have_ff | w_take;
        nxt_w_data = w_take ? s_axi_wdata : w_data_ff;
        nxt_w_strb = w_take ? s_axi_wstrb : w_strb_ff;
        nxt_bvalid = bvalid_ff & ~s_axi_bready;
        nxt_bresp = bresp_ff;
        nxt_cfg = cfg_ff;
        addr = nxt_aw_addr;
        idx = addr[4:2];
        if (nxt_aw_have && nxt_w_have && !bvalid_ff) begin
            nxt_aw_have = 1'b0;
            nxt_w_have = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            if (addr[7:5] == 3'h0 && int'(idx) < NUM_CFG) begin
                // byte lanes through the writable mask
                for (int b = 0; b < 4; b++) begin
                    if (nxt_w_strb[b]) begin
                        nxt_cfg[idx][b*8 +: 8] = nxt_w_data[b*8 +: 8] & WR_MASK[idx][b*8 +: 8];
                    end
                end
            end else if (addr != STATUS_OFF) begin
                nxt_bresp = RESP_SLVERR; // unmapped
            end
        end
    end

    // axi read path: one cycle to data
    always_comb begin
        logic [2:0] ridx; // read word index
        ridx = s_axi_araddr[4:2];
        nxt_rvalid = rvalid_ff & ~s_axi_rready;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            if (s_axi_araddr[7:5] == 3'h0 && int'(ridx) < NUM_CFG) begin
                nxt_rdata = cfg_ff[ridx];
            end else if (s_axi_araddr == STATUS_OFF) begin
                nxt_rdata = status_word;
            end else begin
                nxt_rdata = '0; // unmapped
                nxt_rresp = RESP_SLVERR;
            end
        end
    end

    // register bus state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_ff[i] <= CFG_RESET;
            end
            aw_have_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_have_ff <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            cfg_ff <= nxt_cfg;
            aw_have_ff <= nxt_aw_have;
            aw_addr_ff <= nxt_aw_addr;
            w_have_ff <= nxt_w_have;
            w_data_ff <= nxt_w_data;
            w_strb_ff <= nxt_w_strb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // handshake outputs
    assign s_axi_awready = ~aw_have_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_have_ff & ~bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // routed sinks
    assign conv_trig_o = conv_ff;
    assign cmp_trigger_o = cmp_ff;
    assign serial_tx_o = tx_ff;
    assign serial_rx_o = rx_ff;
    assign dma_request_o = dma_ff;
    assign timebase_count_o = tb_ff;

endmodule : peripheral_trigger_routing
`default_nettype wire

// File: test/trig_route_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module trig_route_monitor
    import trig_route_pkg::*;
#(
    parameter int NUM_TIMERS = 3, // timer units
    parameter int NUM_FLEX = 4, // flexible i/o timers
    parameter int TB_W = 16 // timebase width
) (
    input wire logic clk_i, // bus clock
    input wire logic rst_n_i, // reset, low
    input wire trig_src_t src_i, // event sources
    input wire logic [TB_W-1:0] t1_timebase_i, // timer1 counter
    input wire logic [1:0] serial_tx_i, // transmit data
    input wire logic [1:0] serial_rx_pin_i, // receive pins
    input wire conv_trig_t conv_trig_o, // converter trigger
    input wire logic cmp_trigger_o, // comparator trigger
    input wire logic [NUM_TIMERS-1:0] timer_trigger_o, // timer triggers
    input wire logic [TB_W-1:0] timebase_count_o, // shared timebase
    input wire logic [NUM_FLEX-1:0] flex_trigger_o, // flexible i/o triggers
    input wire logic [1:0] serial_tx_o, // transmit pins
    input wire logic [1:0] serial_rx_o, // receive inputs
    input wire logic [1:0] dma_request_o // dma requests
);
    // one clock domain
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_conv_src;
        conv_trig_o.trigger |-> |$past(src_i);
    endproperty
    a_conv_src: assert property (p_conv_src) else $error("conv w/o source");
    property p_cmp_src;
        $rose(cmp_trigger_o) |-> $past(src_i.low_power_timer_trigger);
    endproperty
    a_cmp_src: assert property (p_cmp_src) else $error("cmp w/o source");
    property p_dma_zero;
        !src_i.periodic_flag_zero [*2] |=> !dma_request_o[0];
    endproperty
    a_dma_zero: assert property (p_dma_zero) else $error("dma0 w/o flag");
    property p_dma_one;
        dma_request_o[1] |-> $past(src_i.periodic_flag_one);
    endproperty
    a_dma_one: assert property (p_dma_one) else $error("dma1 w/o flag");
    property p_tx_mod;
        $past(rst_n_i) |-> (serial_tx_o & ~$past(serial_tx_i)) == 2'h0;
    endproperty
    a_tx_mod: assert property (p_tx_mod) else $error("tx w/o data");
    property p_rx_route;
        $past(rst_n_i) |-> (serial_rx_o[0] == $past(serial_rx_pin_i[0])
            || serial_rx_o[0] == $past(src_i.comparator_output));
    endproperty
    a_rx_route: assert property (p_rx_route) else $error("rx from no source");
    property p_timebase;
        $past(rst_n_i) |-> timebase_count_o == $past(t1_timebase_i);
    endproperty
    a_timebase: assert property (p_timebase) else $error("timebase not copied");
    property p_timer_src;
        timer_trigger_o != '0 |-> |$past(src_i);
    endproperty
    a_timer_src: assert property (p_timer_src) else $error("timer w/o source");
    property p_flex_src;
        flex_trigger_o != '0 |-> |$past(src_i);
    endproperty
    a_flex_src: assert property (p_flex_src) else $error("flex w/o source");
endmodule : trig_route_monitor
bind peripheral_trigger_routing trig_route_monitor #(
    .NUM_TIMERS(NUM_TIMERS), .NUM_FLEX(NUM_FLEX), .TB_W(TB_W)
) u_trig_route_monitor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .src_i(src_i), .t1_timebase_i(t1_timebase_i),
    .serial_tx_i(serial_tx_i), .serial_rx_pin_i(serial_rx_pin_i),
    .conv_trig_o(conv_trig_o), .cmp_trigger_o(cmp_trigger_o),
    .timer_trigger_o(timer_trigger_o), .timebase_count_o(timebase_count_o),
    .flex_trigger_o(flex_trigger_o), .serial_tx_o(serial_tx_o),
    .serial_rx_o(serial_rx_o), .dma_request_o(dma_request_o)
);
`default_nettype wire

// File: test/periph_event_model.sv
`timescale 1ns/10ps
`default_nettype none
module periph_event_model
    import trig_route_pkg::*;
(
    input wire logic clk_i, // bus clock
    input wire logic rst_n_i, // reset, low
    input wire trig_src_t pattern_i, // wanted event levels
    output var trig_src_t src_o, // event flags
    output var logic [15:0] timebase_o // timer1 counter
);
    trig_src_t nxt_src; // next flags
    logic [15:0] nxt_tb; // next count
    // flags change on bus edges only
    // run mode only, no stop-mode spacing
    always_comb begin
        nxt_src = rst_n_i ? pattern_i : '0;
        nxt_tb = rst_n_i ? timebase_o + 16'h0001 : 16'h0000;
    end
    // register flags and count
    always_ff @(posedge clk_i) begin
        src_o <= nxt_src;
        timebase_o <= nxt_tb;
    end
endmodule : periph_event_model
`default_nettype wire

// File: test/peripheral_trigger_routing_tb.sv
`timescale 1ns/10ps
`default_nettype none
module peripheral_trigger_routing_tb
    import trig_route_pkg::*;
    ;
    typedef struct packed {
        logic [7:0] addr; // register written
        logic [31:0] data; // value written
        trig_src_t pat; // event levels
        logic [3:0] pins; // tx data, rx pins
        logic [15:0] exp; // conv, cmp, timer, flex, tx, rx, dma
    } row_t;
    localparam row_t ROWS [10] = '{
        '{CONV_CTRL_OFF, 32'h0000_0000, 13'h0004, 4'hE, 16'h8038},
        '{CONV_CTRL_OFF, 32'h0000_0000, 13'h0006, 4'h5, 16'hC014},
        '{CONV_CTRL_OFF, 32'h0000_0033, 13'h0008, 4'h0, 16'hC000},
        '{CMP_CTRL_OFF, 32'h0000_0001, 13'h1008, 4'hF, 16'hFFFC},
        '{DMA_CTRL_OFF, 32'h0000_0003, 13'h0400, 4'h0, 16'h4001},
        '{TIMER_TRIG_OFF, 32'h0000_5A32, 13'h0600, 4'h0, 16'h4C03},
        '{FLEX_TRIG_OFF, 32'h0000_7654, 13'h0140, 4'h0, 16'h4140},
        '{SERIAL_CTRL_OFF, 32'h0000_0019, 13'h0804, 4'hC, 16'h4014},
        '{FLEX_TRIG_OFF, 32'h0000_8019, 13'h1018, 4'hA, 16'hE348},
        '{CONV_CTRL_OFF, 32'h0000_000F, 13'h0020, 4'h0, 16'h8000}
    };
    logic clk_i = 1'b0; // bus clock
    logic rst_n_i = 1'b0; // reset, low
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // addresses
    logic [31:0] s_axi_wdata = 32'h0000_0000; // write data
    logic [3:0] s_axi_wstrb = 4'h0; // byte enables
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // write side
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // read side
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // answers
    logic [1:0] s_axi_bresp, s_axi_rresp; // responses
    logic [31:0] s_axi_rdata; // read data
    trig_src_t pattern = '0, src; // events
    logic [15:0] tb_val, timebase_count_o; // timebase
    logic [1:0] serial_tx_i = 2'h0, serial_rx_pin_i = 2'h0, serial_tx_o, serial_rx_o;
    conv_trig_t conv_trig_o; // converter trigger
    logic cmp_trigger_o; // comparator trigger
    logic [2:0] timer_trigger_o, timebase_enable_o; // timer sinks
    logic [3:0] flex_trigger_o; // flexible i/o sinks
    logic [1:0] dma_request_o; // dma sinks
    logic [15:0] route_vec;
    int errors = 0, checked = 0; // tallies
    assign route_vec = {conv_trig_o, cmp_trigger_o, timer_trigger_o, flex_trigger_o,
        serial_tx_o, serial_rx_o, dma_request_o};
    always #25 clk_i = ~clk_i;
    periph_event_model u_periph_event_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .pattern_i(pattern), .src_o(src), .timebase_o(tb_val));
    peripheral_trigger_routing u_peripheral_trigger_routing (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .src_i(src),
        .t1_timebase_i(tb_val), .serial_tx_i(serial_tx_i), .serial_rx_pin_i(serial_rx_pin_i),
        .conv_trig_o(conv_trig_o), .cmp_trigger_o(cmp_trigger_o),
        .timer_trigger_o(timer_trigger_o), .timebase_enable_o(timebase_enable_o),
        .timebase_count_o(timebase_count_o), .flex_trigger_o(flex_trigger_o),
        .serial_tx_o(serial_tx_o), .serial_rx_o(serial_rx_o), .dma_request_o(dma_request_o));
    // verdict
    task automatic tally_and_finish();
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // route compare
    task automatic check_route(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: routes %h want %h", $time, got, exp);
        end
    endtask : check_route
    // word compare
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: word %h want %h", $time, got, exp);
        end
    endtask : check_word
    // write: aw and w together, each dropped when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [1:0] resp);
        @(posedge clk_i);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        errors++;
        tally_and_finish();
    endtask : axi_write
    // read: address held until taken
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clk_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                {d, resp} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
                return;
            end
        end
        errors++;
        tally_and_finish();
    endtask : axi_read
    // reset, rows, registers, faults, second reset
    initial begin
        logic [31:0] rd;
        logic [1:0] rsp;
        repeat (19) @(posedge clk_i);
        @(negedge clk_i);
        check_route(route_vec, 16'h003C);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < NUM_REGS; i++) begin
            axi_read(8'(4 * i), rd, rsp);
            check_word({rd[29:0], rsp}, 32'h0000_0000);
        end
        for (int i = 0; i < 10; i++) begin
            axi_write(ROWS[i].addr, ROWS[i].data, 4'hF, rsp);
            pattern <= ROWS[i].pat;
            {serial_tx_i, serial_rx_pin_i} <= ROWS[i].pins;
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            check_route(route_vec, ROWS[i].exp);
        end
        axi_read(TIMER_TRIG_OFF, rd, rsp);
        check_word(rd, 32'h0000_5A32);
        check_word(32'(timebase_enable_o), 32'h0000_0005);
        axi_write(SERIAL_CTRL_OFF, 32'hFFFF_FFFF, 4'hF, rsp);
        axi_read(SERIAL_CTRL_OFF, rd, rsp);
        check_word(rd, 32'h0000_003F);
        axi_write(CONV_CTRL_OFF, 32'h0000_0030, 4'h0, rsp);
        axi_read(CONV_CTRL_OFF, rd, rsp);
        check_word(rd, 32'h0000_000F);
        axi_write(8'h40, 32'h0000_0001, 4'hF, rsp);
        check_word(32'(rsp), 32'(RESP_SLVERR));
        axi_read(8'h40, rd, rsp);
        check_word({rd[29:0], rsp}, 32'(RESP_SLVERR));
        axi_write(STATUS_OFF, 32'hFFFF_FFFF, 4'hF, rsp);
        check_word(32'(rsp), 32'(RESP_OKAY));
        @(negedge clk_i);
        check_word(32'(timebase_count_o), 32'(tb_val - 16'h0001));
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        pattern <= 13'h0002;
        {serial_tx_i, serial_rx_pin_i} <= 4'h0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check_route(route_vec, 16'h003C);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        axi_read(CONV_CTRL_OFF, rd, rsp);
        check_word(rd, 32'h0000_0000);
        @(negedge clk_i);
        check_route(route_vec, 16'hC000);
        tally_and_finish();
    end
endmodule : peripheral_trigger_routing_tb
`default_nettype wire
